/* File: ebh_arbiter.sv */
// bus hold arbiter of the external memory port
// How it works
// - bus request passes a two-stage synchroniser, so it may arrive asynchronously.
// - outputs float no sooner than four cycles after request goes low.
// - acknowledge goes low at most two cycles after outputs float.
// - acknowledge returns high four to seven cycles after request release.
// - outputs are driven again three to six cycles after request release.
// - pending memory transfers finish before floating and acknowledging.
// - with no transfer in progress, grant follows with the least delay.
// - while grant disable is set, no grant is ever given.
// - all memory port outputs float while granted, driven again one cycle before acknowledge returns high.
`timescale 1ns/1ps
`include "ebh_defs.svh"
module ebh_arbiter
  import ebh_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic bus_request_n_i,
  input wire logic grant_disable_i,
  input wire logic mem_busy_i,
  output logic mem_stall_o,
  output logic bus_grant_ack_n_o,
  input wire logic [`EBH_CE_W-1:0] mem_chip_enables_n_i,
  input wire logic [`EBH_BE_W-1:0] mem_byte_enables_n_i,
  input wire logic [`EBH_ADDR_HI:`EBH_ADDR_LO] mem_addr_i,
  input wire logic [`EBH_DATA_W-1:0] mem_wr_data_i,
  input wire logic mem_wr_data_oe_i,
  output logic [`EBH_DATA_W-1:0] mem_rd_data_o,
  input wire logic mem_async_read_strobe_n_i,
  input wire logic mem_async_output_enable_n_i,
  input wire logic mem_async_write_strobe_n_i,
  input wire logic mem_burst_sram_addr_strobe_n_i,
  input wire logic mem_burst_sram_output_enable_n_i,
  input wire logic mem_burst_sram_write_enable_n_i,
  input wire logic mem_sdram_addr_bit_ten_i,
  input wire logic mem_sdram_row_strobe_n_i,
  input wire logic mem_sdram_column_strobe_n_i,
  input wire logic mem_sdram_write_enable_n_i,
  output logic ext_bus_oe_o,
  output logic [`EBH_CE_W-1:0] chip_enables_n_o,
  output logic [`EBH_BE_W-1:0] byte_enables_n_o,
  output logic [`EBH_ADDR_HI:`EBH_ADDR_LO] ext_addr_bus_o,
  input wire logic [`EBH_DATA_W-1:0] ext_data_bus_i,
  output logic [`EBH_DATA_W-1:0] ext_data_bus_o,
  output logic ext_data_bus_oe_o,
  output logic async_read_strobe_n_o,
  output logic async_output_enable_n_o,
  output logic async_write_strobe_n_o,
  output logic burst_sram_addr_strobe_n_o,
  output logic burst_sram_output_enable_n_o,
  output logic burst_sram_write_enable_n_o,
  output logic sdram_addr_bit_ten_o,
  output logic sdram_row_strobe_n_o,
  output logic sdram_column_strobe_n_o,
  output logic sdram_write_enable_n_o
);

  ebh_regs_t r;
  ebh_regs_t n;
  logic req_s;

  ////////////////////////////////////////////////////////////////////////////
  // request synchroniser

  ebh_sync #(
    .RST_VAL(`EBH_OFF_N)
  ) u_req_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i(bus_request_n_i),
    .q_o(req_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    n = r;
    // output stage follows the memory controller every cycle
    n.ce_n = mem_chip_enables_n_i;
    n.be_n = mem_byte_enables_n_i;
    n.addr = mem_addr_i;
    n.data = mem_wr_data_i;
    n.data_oe = mem_wr_data_oe_i;
    n.rd_data = ext_data_bus_i;
    n.are_n = mem_async_read_strobe_n_i;
    n.aoe_n = mem_async_output_enable_n_i;
    n.awe_n = mem_async_write_strobe_n_i;
    n.burst_sram_addr_strobe_n_n = mem_burst_sram_addr_strobe_n_i;
    n.burst_sram_output_enable_n_n = mem_burst_sram_output_enable_n_i;
    n.burst_sram_write_enable_n_n = mem_burst_sram_write_enable_n_i;
    n.sdram_addr_bit_ten = mem_sdram_addr_bit_ten_i;
    n.sdram_row_strobe_n_n = mem_sdram_row_strobe_n_i;
    n.sdram_column_strobe_n_n = mem_sdram_column_strobe_n_i;
    n.sdram_write_enable_n_n = mem_sdram_write_enable_n_i;
    // saturating phase counter
    if (r.cnt != '1)
    begin
      n.cnt = r.cnt + `EBH_CNT_W'(1);
    end
    unique case (r.st)
      EBH_IDLE:
      begin
        n.cnt = '0;
        if (!req_s && !grant_disable_i)
        begin
          n.st = EBH_WAIT;
        end
      end
      EBH_WAIT:
      begin
        if (req_s || grant_disable_i)
        begin
          n.st = EBH_IDLE;
        end
        else if (r.cnt >= `EBH_CNT_W'(`EBH_HZ_MATCH) && !mem_busy_i)
        begin
          n.st = EBH_FLOAT;
          n.bus_oe = `EBH_OFF;
        end
      end
      EBH_FLOAT:
      begin
        n.cnt = '0;
        if (grant_disable_i)
        begin
          n.st = EBH_RESUME;
        end
        else
        begin
          n.st = EBH_GRANT;
          n.ack_n = `EBH_OFF;
        end
      end
      EBH_GRANT:
      begin
        n.cnt = '0;
        if (req_s)
        begin
          n.st = EBH_RESUME;
        end
      end
      EBH_RESUME:
      begin
        if (r.cnt == `EBH_CNT_W'(`EBH_REDRIVE_MATCH))
        begin
          n.bus_oe = `EBH_ON;
        end
        if (r.cnt == `EBH_CNT_W'(`EBH_ACKOFF_MATCH))
        begin
          n.ack_n = `EBH_OFF_N;
          n.st = EBH_IDLE;
        end
      end
      default:
      begin
        n.st = EBH_IDLE;
        n.bus_oe = `EBH_ON;
        n.ack_n = `EBH_OFF_N;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      r <= '{st: EBH_IDLE, cnt: '0, ack_n: `EBH_OFF_N, bus_oe: `EBH_ON, data_oe: `EBH_OFF,
             ce_n: '1, be_n: '1, addr: '0, data: '0, rd_data: '0,
             are_n: `EBH_OFF_N, aoe_n: `EBH_OFF_N, awe_n: `EBH_OFF_N,
             burst_sram_addr_strobe_n_n: `EBH_OFF_N, burst_sram_output_enable_n_n: `EBH_OFF_N, burst_sram_write_enable_n_n: `EBH_OFF_N,
             sdram_addr_bit_ten: `EBH_OFF, sdram_row_strobe_n_n: `EBH_OFF_N, sdram_column_strobe_n_n: `EBH_OFF_N, sdram_write_enable_n_n: `EBH_OFF_N};
    end
    else
    begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign mem_stall_o = (r.st != EBH_IDLE);
  assign bus_grant_ack_n_o = r.ack_n;
  assign ext_bus_oe_o = r.bus_oe;
  assign ext_data_bus_oe_o = r.bus_oe & r.data_oe;
  assign chip_enables_n_o = r.ce_n;
  assign byte_enables_n_o = r.be_n;
  assign ext_addr_bus_o = r.addr;
  assign ext_data_bus_o = r.data;
  assign mem_rd_data_o = r.rd_data;
  assign async_read_strobe_n_o = r.are_n;
  assign async_output_enable_n_o = r.aoe_n;
  assign async_write_strobe_n_o = r.awe_n;
  assign burst_sram_addr_strobe_n_o = r.burst_sram_addr_strobe_n_n;
  assign burst_sram_output_enable_n_o = r.burst_sram_output_enable_n_n;
  assign burst_sram_write_enable_n_o = r.burst_sram_write_enable_n_n;
  assign sdram_addr_bit_ten_o = r.sdram_addr_bit_ten;
  assign sdram_row_strobe_n_o = r.sdram_row_strobe_n_n;
  assign sdram_column_strobe_n_o = r.sdram_column_strobe_n_n;
  assign sdram_write_enable_n_o = r.sdram_write_enable_n_n;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_REQ_SYNC:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      req_s == $past(bus_request_n_i, 2))
    else $error("request synchroniser latency wrong");

  AST_FLOAT_MIN:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $fell(ext_bus_oe_o) |-> (!$past(bus_request_n_i, 5) && !$past(bus_request_n_i, 3)))
    else $error("port floated before least delay");

  AST_ACK_AFTER_FLOAT:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $fell(ext_bus_oe_o) && !grant_disable_i |-> ##[1:2] !bus_grant_ack_n_o)
    else $error("acknowledge late after float");

  AST_ACK_RELEASE:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(bus_request_n_i) && !$past(bus_request_n_i, 2) && r.st == EBH_GRANT
      |-> !bus_grant_ack_n_o [*5] ##[1:3] bus_grant_ack_n_o)
    else $error("acknowledge release outside window");

  AST_REDRIVE:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(bus_request_n_i) && !$past(bus_request_n_i, 2) && r.st == EBH_GRANT
      |-> !ext_bus_oe_o [*4] ##[1:3] ext_bus_oe_o)
    else $error("port not driven again in window");

  AST_DRAIN:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $fell(ext_bus_oe_o) |-> !$past(mem_busy_i))
    else $error("port floated during a transfer");

  AST_FAST_GRANT:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      r.st == EBH_IDLE && $fell(bus_request_n_i)
      ##1 (!bus_request_n_i && !mem_busy_i && !grant_disable_i) [*5]
      |=> !bus_grant_ack_n_o)
    else $error("idle grant slower than least delay");

  AST_NO_GRANT:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      grant_disable_i && bus_grant_ack_n_o |=> bus_grant_ack_n_o)
    else $error("grant given while disabled");

  AST_FLOATED:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !bus_grant_ack_n_o && r.st != EBH_RESUME |-> !ext_bus_oe_o && !ext_data_bus_oe_o)
    else $error("port driven while granted");

  AST_STALL:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !bus_grant_ack_n_o |-> mem_stall_o)
    else $error("transfers not held off while granted");

endmodule

/* File: ebh_defs.svh */
// named constants for the external bus hold arbiter
`ifndef EBH_DEFS_SVH
`define EBH_DEFS_SVH

// clock and cpu period, in ns
`define EBH_CLK_NS 4
`define EBH_P_NS 4

// response windows, in cpu clock periods
`define EBH_HZ_MIN_P 4
`define EBH_ACK_MAX_P 2
`define EBH_ACKOFF_MIN_P 4
`define EBH_ACKOFF_MAX_P 7
`define EBH_REDRIVE_MIN_P 3
`define EBH_REDRIVE_MAX_P 6

// least times round up to whole cycles
`define EBH_HZ_MIN_CYC ((`EBH_HZ_MIN_P * `EBH_P_NS + `EBH_CLK_NS - 1) / `EBH_CLK_NS)
`define EBH_ACKOFF_MIN_CYC ((`EBH_ACKOFF_MIN_P * `EBH_P_NS + `EBH_CLK_NS - 1) / `EBH_CLK_NS)
`define EBH_REDRIVE_MIN_CYC ((`EBH_REDRIVE_MIN_P * `EBH_P_NS + `EBH_CLK_NS - 1) / `EBH_CLK_NS)

// pin to registered state change: two sync stages plus one decision edge
`define EBH_SEQ_LAT 3

// phase counter
`define EBH_CNT_W 3
`define EBH_HZ_MATCH (`EBH_HZ_MIN_CYC - `EBH_SEQ_LAT)
`define EBH_REDRIVE_MATCH (`EBH_REDRIVE_MIN_CYC - `EBH_SEQ_LAT)
`define EBH_ACKOFF_MATCH (`EBH_ACKOFF_MIN_CYC - `EBH_SEQ_LAT)

// field widths
`define EBH_CE_W 4
`define EBH_BE_W 4
`define EBH_DATA_W 32
`define EBH_ADDR_HI 21
`define EBH_ADDR_LO 2

// reset levels
`define EBH_OFF_N 1'b1
`define EBH_OFF 1'b0
`define EBH_ON 1'b1

`endif

/* File: ebh_master_model.sv */
// outside bus master that borrows the memory bus
`timescale 1ns/1ps
module ebh_master_model
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [7:0] hold_i,
  input wire logic bus_grant_ack_n_i,
  output logic bus_request_n_o
);
  logic [7:0] cnt_r;

  // request, keep the bus hold_i cycles after grant, then let go
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      bus_request_n_o <= 1'b1;
      cnt_r <= 8'h00;
    end
    else if (bus_request_n_o)
    begin
      bus_request_n_o <= !start_i;
      cnt_r <= 8'h00;
    end
    else if (abort_i || (!bus_grant_ack_n_i && cnt_r == hold_i))
      bus_request_n_o <= 1'b1;
    else if (!bus_grant_ack_n_i)
      cnt_r <= cnt_r + 8'h01;
  end
endmodule

/* File: ebh_pkg.sv */
// types of the external bus hold arbiter
package ebh_pkg;
  `include "ebh_defs.svh"

  typedef enum logic [2:0] {
    EBH_IDLE   = 3'h0,
    EBH_WAIT   = 3'h1,
    EBH_FLOAT  = 3'h3,
    EBH_GRANT  = 3'h2,
    EBH_RESUME = 3'h6
  } ebh_state_t;

  typedef struct packed {
    logic meta;
    logic q;
  } ebh_sync_t;

  typedef struct packed {
    ebh_state_t st;
    logic [`EBH_CNT_W-1:0] cnt;
    logic ack_n;
    logic bus_oe;
    logic data_oe;
    logic [`EBH_CE_W-1:0] ce_n;
    logic [`EBH_BE_W-1:0] be_n;
    logic [`EBH_ADDR_HI:`EBH_ADDR_LO] addr;
    logic [`EBH_DATA_W-1:0] data;
    logic [`EBH_DATA_W-1:0] rd_data;
    logic are_n;
    logic aoe_n;
    logic awe_n;
    logic burst_sram_addr_strobe_n_n;
    logic burst_sram_output_enable_n_n;
    logic burst_sram_write_enable_n_n;
    logic sdram_addr_bit_ten;
    logic sdram_row_strobe_n_n;
    logic sdram_column_strobe_n_n;
    logic sdram_write_enable_n_n;
  } ebh_regs_t;
endpackage

/* File: ebh_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
`include "ebh_defs.svh"
module ebh_sync
  import ebh_pkg::*;
#(
  parameter logic RST_VAL = `EBH_OFF_N
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic d_i,
  output logic q_o
);

  ebh_sync_t r;
  ebh_sync_t n;

  // first stage feeds only the second
  always_comb
  begin
    n.meta = d_i;
    n.q = r.meta;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      r <= '{meta: RST_VAL, q: RST_VAL};
    end
    else
    begin
      r <= n;
    end
  end

  assign q_o = r.q;

endmodule

/* File: tb_top.sv */
// testbench of the bus hold arbiter
`timescale 1ns/1ps
module tb_top;
  logic clk_i, rst_b_i, start, abort, busy, dis, woe;
  logic [7:0] hold;
  logic [3:0] ce, be;
  logic [19:0] addr;
  logic [31:0] wd, rdi;
  logic [9:0] st;
  wire logic req_n, ack_n, stall, oe, doe;
  wire logic [3:0] ce_o, be_o;
  wire logic [19:0] addr_o;
  wire logic [31:0] wd_o, rd_o;
  wire logic [9:0] st_o;
  int num_errors, total_checks, n;

  ebh_master_model mst_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start), .abort_i(abort), .hold_i(hold),
    .bus_grant_ack_n_i(ack_n), .bus_request_n_o(req_n));
  ebh_arbiter dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_request_n_i(req_n), .grant_disable_i(dis),
    .mem_busy_i(busy), .mem_stall_o(stall), .bus_grant_ack_n_o(ack_n), .mem_chip_enables_n_i(ce),
    .mem_byte_enables_n_i(be), .mem_addr_i(addr), .mem_wr_data_i(wd), .mem_wr_data_oe_i(woe),
    .mem_rd_data_o(rd_o), .mem_async_read_strobe_n_i(st[0]), .mem_async_output_enable_n_i(st[1]),
    .mem_async_write_strobe_n_i(st[2]), .mem_burst_sram_addr_strobe_n_i(st[3]),
    .mem_burst_sram_output_enable_n_i(st[4]), .mem_burst_sram_write_enable_n_i(st[5]),
    .mem_sdram_addr_bit_ten_i(st[6]), .mem_sdram_row_strobe_n_i(st[7]), .mem_sdram_column_strobe_n_i(st[8]),
    .mem_sdram_write_enable_n_i(st[9]), .ext_bus_oe_o(oe), .chip_enables_n_o(ce_o), .byte_enables_n_o(be_o),
    .ext_addr_bus_o(addr_o), .ext_data_bus_i(rdi), .ext_data_bus_o(wd_o), .ext_data_bus_oe_o(doe),
    .async_read_strobe_n_o(st_o[0]), .async_output_enable_n_o(st_o[1]), .async_write_strobe_n_o(st_o[2]),
    .burst_sram_addr_strobe_n_o(st_o[3]), .burst_sram_output_enable_n_o(st_o[4]),
    .burst_sram_write_enable_n_o(st_o[5]), .sdram_addr_bit_ten_o(st_o[6]), .sdram_row_strobe_n_o(st_o[7]),
    .sdram_column_strobe_n_o(st_o[8]), .sdram_write_enable_n_o(st_o[9]));

  // 250 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // verdict and end of run
  task complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // select 0 float enable, 1 acknowledge, 2 request
  function automatic logic pick(int s);
    return s == 0 ? oe : (s == 1 ? ack_n : req_n);
  endfunction

  // count edges until the chosen signal shows v
  task automatic wait_for(int s, logic v);
    n = 0;
    do
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    while (pick(s) !== v && n < 60);
    if (n >= 60)
    begin
      check("timeout", 32'h0, 32'h1);
      complete_run();
    end
  endtask

  // start one borrow of the bus
  task automatic kick(logic [7:0] h, logic b, logic d);
    @(posedge clk_i);
    start <= 1'b1;
    hold <= h;
    busy <= b;
    dis <= d;
    @(posedge clk_i);
    start <= 1'b0;
  endtask

  // controller values reach the pins one edge later
  task automatic pass(logic [31:0] p, logic exp_oe);
    @(posedge clk_i);
    {ce, be, addr, wd, woe, st, rdi} <= {p[3:0], p[7:4], p[19:0], p, p[0], p[9:0], ~p};
    @(posedge clk_i);
    #1;
    check("pins", {ce_o, be_o, st_o, addr_o[13:0]}, {p[3:0], p[7:4], p[9:0], p[13:0]});
    check("addr", addr_o, p[19:0]);
    check("wdata", wd_o, p);
    check("rdata", rd_o, ~p);
    check("data_oe", doe, p[0] & exp_oe);
    check("bus_oe", oe, exp_oe);
  endtask

  // release: redrive then acknowledge off
  task automatic release_chk();
    // release may already be made while the pins were checked
    if (req_n !== 1'b1)
    begin
      wait_for(2, 1'b1);
    end
    wait_for(0, 1'b1);
    check("redrive", n, 4);
    wait_for(1, 1'b1);
    check("ack_off", n, 1);
    check("stall_off", stall, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // idle port: least delay float, ack, pins tracked while floated
  task automatic s_grant(logic [7:0] h);
    kick(h, 1'b0, 1'b0);
    wait_for(0, 1'b0);
    check("float", n, 5);
    wait_for(1, 1'b0);
    check("ack_on", n, 1);
    check("stall", stall, 1'b1);
    pass(32'h0F0F_F0F1, 1'b0);
    release_chk();
  endtask

  // transfer in progress holds off the float
  task automatic s_busy();
    kick(8'h02, 1'b1, 1'b0);
    repeat (12)
    begin
      @(posedge clk_i);
      #1;
      check("busy_oe", {oe, ack_n}, 2'h3);
    end
    check("busy_stall", stall, 1'b1);
    @(posedge clk_i);
    busy <= 1'b0;
    wait_for(0, 1'b0);
    wait_for(1, 1'b0);
    check("busy_ack", n, 1);
    release_chk();
  endtask

  // grant disabled: request stays unanswered, then withdrawn
  task automatic s_disable();
    kick(8'h02, 1'b0, 1'b1);
    repeat (20)
    begin
      @(posedge clk_i);
      #1;
      check("dis_oe", {oe, ack_n}, 2'h3);
    end
    @(posedge clk_i);
    abort <= 1'b1;
    @(posedge clk_i);
    abort <= 1'b0;
    dis <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    check("dis_idle", {oe, ack_n, stall}, 3'h6);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {rst_b_i, start, abort, busy, dis, woe, hold, ce, be, addr, wd, rdi} = '0;
    st = 10'h3FF;
    num_errors = 0;
    total_checks = 0;
    repeat (2) @(posedge clk_i);
    #1;
    check("reset", {oe, ack_n, stall, doe}, 4'hC);
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    pass(32'hA5C3_3C5B, 1'b1);
    pass(32'h5A3C_C3A4, 1'b1);
    s_grant(8'h01);
    s_grant(8'h08);
    s_busy();
    s_disable();
    s_grant(8'h03);
    complete_run();
  end
endmodule
